// ===== rtl/nxrae_cfg.svh
// opcode encodings, field positions and reset values of the transfer execution block
`ifndef NXRAE_CFG_SVH
`define NXRAE_CFG_SVH

// full 10-bit opcodes of the fixed register transfers
`define NXRAE_OP_SECOND_TO_ACC  10'h01e
`define NXRAE_OP_ACC_TO_SECOND  10'h00e
`define NXRAE_OP_DIGIT_TO_ACC   10'h01f
`define NXRAE_OP_ACC_TO_DIGIT   10'h00c
`define NXRAE_OP_PAIR_TO_WIDE   10'h01a
`define NXRAE_OP_WIDE_TO_PAIR   10'h02a
`define NXRAE_OP_ACC_TO_TEXT    10'h029
`define NXRAE_OP_TEXT_TO_ACC    10'h051
`define NXRAE_OP_PAGE_TO_ACC    10'h053
`define NXRAE_OP_FILE_TO_ACC    10'h052
`define NXRAE_OP_SPTR_TO_ACC    10'h050
`define NXRAE_OP_DIGIT_INC      10'h013
`define NXRAE_OP_DIGIT_DEC      10'h017

// field-carrying opcodes: prefix values and their bit spans
`define NXRAE_PAIR_PFX_HI       9
`define NXRAE_PAIR_PFX_LO       8
`define NXRAE_PAIR_PFX          2'h3
`define NXRAE_PAGE_PFX_HI       9
`define NXRAE_PAGE_PFX_LO       2
`define NXRAE_PAGE_PFX          8'h12
`define NXRAE_RAM_PFX_HI        9
`define NXRAE_RAM_PFX_LO        4
`define NXRAE_PFX_RAM_LOAD      6'h2c
`define NXRAE_PFX_RAM_SWAP      6'h2d
`define NXRAE_PFX_RAM_SWAP_DEC  6'h2f
`define NXRAE_PFX_RAM_SWAP_INC  6'h2e
`define NXRAE_PFX_RAM_STORE     6'h2b

// immediate field positions
`define NXRAE_X_HI              7
`define NXRAE_X_LO              4
`define NXRAE_Y_HI              3
`define NXRAE_Y_LO              0
`define NXRAE_Z_HI              1
`define NXRAE_Z_LO              0
`define NXRAE_J_HI              3
`define NXRAE_J_LO              0

// digit values that trigger a skip
`define NXRAE_DIGIT_WRAP_UP     4'h0
`define NXRAE_DIGIT_WRAP_DN     4'hf

// reset values
`define NXRAE_RST_NIB           4'h0
`define NXRAE_RST_WIDE          8'h00
`define NXRAE_RST_PAGE          2'h0
`define NXRAE_RST_TEXT          3'h0
`define NXRAE_RST_ADDR          10'h000
`define NXRAE_RST_BIT           1'h0

`endif

// ===== rtl/nxrae_exec.sv
// execution of register transfers, ram address loads and ram-to-register transfers
`timescale 1ns/10ps
`include "nxrae_cfg.svh"

// Summary of operation
// - B-to-acc copies B into accumulator
// - acc-to-B copies accumulator into B
// - digit-to-acc copies digit register into accumulator
// - acc-to-digit loads digit register from accumulator
// - pack loads wide register from B:acc
// - unpack splits wide register into B, acc
// - acc-to-table-ext copies accumulator into D
// - table-ext-to-acc copies D into accumulator
// - page-to-acc copies page register into accumulator
// - file-to-acc copies file register into accumulator
// - stackptr-to-acc copies stack pointer into accumulator
// - pair load writes file and digit immediates
// - consecutive pair loads after first are skipped
// - page load writes z immediate to page
// - digit increment wraps, skips next on zero
// - digit decrement wraps, skips next on fifteen
// - ram load to acc, file xor j
// - ram swap with acc, file xor j
// - swap, xor, decrement digit, skip on fifteen
// - swap, xor, increment digit, skip on zero
// - ram store from acc, file xor j
// - page register holds only zero to three
// - D to acc clears accumulator bit three
module nxrae_exec (
  input  wire logic        clk_in,             // instruction cycle clock
  input  wire logic        resetn_in,          // async reset, active low
  input  wire logic        exec_in,            // one instruction presented this cycle
  input  wire logic [9:0]  instr_in,           // instruction word
  input  wire logic        skip_in,            // sequencer marks this instruction skipped
  input  wire logic [3:0]  ram_nibble_in,      // ram nibble at the data pointer
  input  wire logic [2:0]  stack_pointer_in,   // current stack pointer
  output logic      [3:0]  acc_out,            // accumulator
  output logic      [3:0]  second_out,         // register B
  output logic      [7:0]  wide_out,           // register E
  output logic      [3:0]  digit_out,          // ram digit address Y
  output logic      [3:0]  file_out,           // ram file address X
  output logic      [1:0]  page_out,           // ram page Z
  output logic      [2:0]  table_ext_out,      // table pointer extension D
  output logic             skip_next_out,      // pulse: skip the following instruction
  output logic             ram_we_out,         // pulse: write ram nibble
  output logic      [3:0]  ram_wdata_out,      // nibble to write
  output logic      [9:0]  ram_waddr_out       // pointer {page,file,digit} of the write
);

  // architectural registers and their next values
  logic [3:0] acc_r,        acc_nxt;
  logic [3:0] second_r,     second_nxt;
  logic [7:0] wide_r,       wide_nxt;
  logic [3:0] digit_r,      digit_nxt;
  logic [3:0] file_r,       file_nxt;
  logic [1:0] page_r,       page_nxt;
  logic [2:0] table_ext_r,  table_ext_nxt;
  // sequencing state
  // skip request leaves as a one-cycle pulse; the sequencer does the
  // actual suppression and hands it back through skip_in
  logic       skip_next_r,  skip_next_nxt;
  // run tracker: set by any presented pair load, skipped ones too,
  // so later members of a run stay held off; idle cycles keep it
  logic       pair_run_r,   pair_run_nxt;  // previous instruction was a pair load
  // ram write port
  // write lands one cycle after the read, at the pointer latched then,
  // so a file or digit step by the same word cannot move the write
  logic       ram_we_r,     ram_we_nxt;
  logic [3:0] ram_wdata_r,  ram_wdata_nxt;
  logic [9:0] ram_waddr_r,  ram_waddr_nxt;

  nxrae_pkg::nxrae_op_t op;                // decoded instruction kind
  logic                 squash;            // instruction must have no effect
  logic [3:0]           digit_up;          // digit plus one, mod 16
  logic [3:0]           digit_dn;          // digit minus one, mod 16
  logic [3:0]           file_xor;          // file xor j immediate

  // map an instruction word onto its kind; other groups decode to none
  // pair load owns the whole upper quarter of the code space, so it is
  // tested first; page load next; then the ram group prefixes, and
  // last the fixed single-word opcodes
  function automatic nxrae_pkg::nxrae_op_t nxrae_decode(input logic [9:0] w);
    nxrae_pkg::nxrae_op_t k;
    k = nxrae_pkg::NXRAE_NONE;
    if (w[`NXRAE_PAIR_PFX_HI:`NXRAE_PAIR_PFX_LO] == `NXRAE_PAIR_PFX) begin
      k = nxrae_pkg::NXRAE_LOAD_FILE_DIGIT_IMM;
    end else if (w[`NXRAE_PAGE_PFX_HI:`NXRAE_PAGE_PFX_LO] == `NXRAE_PAGE_PFX) begin
      k = nxrae_pkg::NXRAE_LOAD_PAGE_IMM;
    end else begin
      unique case (w[`NXRAE_RAM_PFX_HI:`NXRAE_RAM_PFX_LO])
        `NXRAE_PFX_RAM_LOAD:     k = nxrae_pkg::NXRAE_RAM_LOAD_ACC;
        `NXRAE_PFX_RAM_SWAP:     k = nxrae_pkg::NXRAE_RAM_SWAP_ACC;
        `NXRAE_PFX_RAM_SWAP_DEC: k = nxrae_pkg::NXRAE_RAM_SWAP_DEC_SKIP;
        `NXRAE_PFX_RAM_SWAP_INC: k = nxrae_pkg::NXRAE_RAM_SWAP_INC_SKIP;
        `NXRAE_PFX_RAM_STORE:    k = nxrae_pkg::NXRAE_RAM_STORE_ACC;
        default: begin
          // fixed opcodes; anything else belongs to another group
          unique case (w)
            `NXRAE_OP_SECOND_TO_ACC: k = nxrae_pkg::NXRAE_COPY_SECOND_TO_ACC;
            `NXRAE_OP_ACC_TO_SECOND: k = nxrae_pkg::NXRAE_COPY_ACC_TO_SECOND;
            `NXRAE_OP_DIGIT_TO_ACC:  k = nxrae_pkg::NXRAE_COPY_DIGIT_TO_ACC;
            `NXRAE_OP_ACC_TO_DIGIT:  k = nxrae_pkg::NXRAE_COPY_ACC_TO_DIGIT;
            `NXRAE_OP_PAIR_TO_WIDE:  k = nxrae_pkg::NXRAE_PACK_PAIR_TO_WIDE;
            `NXRAE_OP_WIDE_TO_PAIR:  k = nxrae_pkg::NXRAE_UNPACK_WIDE_TO_PAIR;
            `NXRAE_OP_ACC_TO_TEXT:   k = nxrae_pkg::NXRAE_COPY_ACC_TO_TABLE_EXT;
            `NXRAE_OP_TEXT_TO_ACC:   k = nxrae_pkg::NXRAE_COPY_TABLE_EXT_TO_ACC;
            `NXRAE_OP_PAGE_TO_ACC:   k = nxrae_pkg::NXRAE_COPY_PAGE_TO_ACC;
            `NXRAE_OP_FILE_TO_ACC:   k = nxrae_pkg::NXRAE_COPY_FILE_TO_ACC;
            `NXRAE_OP_SPTR_TO_ACC:   k = nxrae_pkg::NXRAE_COPY_STACKPTR_TO_ACC;
            `NXRAE_OP_DIGIT_INC:     k = nxrae_pkg::NXRAE_DIGIT_INCREMENT_SKIP;
            `NXRAE_OP_DIGIT_DEC:     k = nxrae_pkg::NXRAE_DIGIT_DECREMENT_SKIP;
            default:                 k = nxrae_pkg::NXRAE_NONE;
          endcase
        end
      endcase
    end
    return k;
  endfunction

  // decode and shared arithmetic
  // both digit steps formed once, shared by plain and swap forms
  always_comb begin
    op       = nxrae_decode(instr_in);
    digit_up = digit_r + 4'h1;  // wraps f to 0
    digit_dn = digit_r - 4'h1;  // wraps 0 to f
    // j sits in the low nibble of every ram group word
    file_xor = file_r ^ instr_in[`NXRAE_J_HI:`NXRAE_J_LO];
    // skipped by sequencer, or a pair load following a pair load
    squash   = skip_in ||
               (pair_run_r && (op == nxrae_pkg::NXRAE_LOAD_FILE_DIGIT_IMM));
  end

  // next-state of registers, skip request and ram write
  always_comb begin
    // every register holds unless the word below changes it
    acc_nxt       = acc_r;
    second_nxt    = second_r;
    wide_nxt      = wide_r;
    digit_nxt     = digit_r;
    file_nxt      = file_r;
    page_nxt      = page_r;
    table_ext_nxt = table_ext_r;
    // pulses fall back to zero unless this word raises them
    skip_next_nxt = 1'h0;
    pair_run_nxt  = pair_run_r;
    ram_we_nxt    = 1'h0;
    // write data and address hold so the port stays quiet when idle
    ram_wdata_nxt = ram_wdata_r;
    ram_waddr_nxt = ram_waddr_r;
    // idle cycles leave the pair-load run as it stands
    if (exec_in) begin
      // a run of pair loads is tracked across skipped members too
      pair_run_nxt = (op == nxrae_pkg::NXRAE_LOAD_FILE_DIGIT_IMM);
      // a squashed word still takes part in run tracking above
      if (!squash) begin
        // no carry state lives here, so carry is never touched
        unique case (op)
          nxrae_pkg::NXRAE_COPY_SECOND_TO_ACC: begin
            acc_nxt = second_r;
          end
          nxrae_pkg::NXRAE_COPY_ACC_TO_SECOND: begin
            second_nxt = acc_r;
          end
          nxrae_pkg::NXRAE_COPY_DIGIT_TO_ACC: begin
            acc_nxt = digit_r;
          end
          nxrae_pkg::NXRAE_COPY_ACC_TO_DIGIT: begin
            digit_nxt = acc_r;
          end
          nxrae_pkg::NXRAE_PACK_PAIR_TO_WIDE: begin
            // b becomes the high nibble of e
            wide_nxt = {second_r, acc_r};
          end
          nxrae_pkg::NXRAE_UNPACK_WIDE_TO_PAIR: begin
            // high nibble to b, low nibble to accumulator
            second_nxt = wide_r[7:4];
            acc_nxt    = wide_r[3:0];
          end
          nxrae_pkg::NXRAE_COPY_ACC_TO_TABLE_EXT: begin
            // only the low three accumulator bits fit
            table_ext_nxt = acc_r[2:0];
          end
          nxrae_pkg::NXRAE_COPY_TABLE_EXT_TO_ACC: begin
            // three-bit source; top accumulator bit forced low
            acc_nxt = {1'h0, table_ext_r};
          end
          nxrae_pkg::NXRAE_COPY_PAGE_TO_ACC: begin
            // two-bit page; upper accumulator bits cleared
            acc_nxt = {2'h0, page_r};
          end
          nxrae_pkg::NXRAE_COPY_FILE_TO_ACC: begin
            acc_nxt = file_r;
          end
          nxrae_pkg::NXRAE_COPY_STACKPTR_TO_ACC: begin
            // three-bit stack pointer; bit 3 cleared
            acc_nxt = {1'h0, stack_pointer_in};
          end
          nxrae_pkg::NXRAE_LOAD_FILE_DIGIT_IMM: begin
            // x immediate in the upper nibble, y in the lower
            file_nxt  = instr_in[`NXRAE_X_HI:`NXRAE_X_LO];
            digit_nxt = instr_in[`NXRAE_Y_HI:`NXRAE_Y_LO];
          end
          nxrae_pkg::NXRAE_LOAD_PAGE_IMM: begin
            // two-bit immediate, so the page never exceeds three
            page_nxt = instr_in[`NXRAE_Z_HI:`NXRAE_Z_LO];
          end
          nxrae_pkg::NXRAE_DIGIT_INCREMENT_SKIP: begin
            // skip when the step wraps to zero
            digit_nxt     = digit_up;
            skip_next_nxt = (digit_up == `NXRAE_DIGIT_WRAP_UP);
          end
          nxrae_pkg::NXRAE_DIGIT_DECREMENT_SKIP: begin
            // skip when the step wraps to fifteen
            digit_nxt     = digit_dn;
            skip_next_nxt = (digit_dn == `NXRAE_DIGIT_WRAP_DN);
          end
          nxrae_pkg::NXRAE_RAM_LOAD_ACC: begin
            acc_nxt  = ram_nibble_in;
            file_nxt = file_xor;
          end
          nxrae_pkg::NXRAE_RAM_SWAP_ACC: begin
            // ram read now, old accumulator written one cycle later
            acc_nxt       = ram_nibble_in;
            ram_we_nxt    = 1'h1;
            ram_wdata_nxt = acc_r;
            ram_waddr_nxt = {page_r, file_r, digit_r};
            file_nxt      = file_xor;
          end
          nxrae_pkg::NXRAE_RAM_SWAP_DEC_SKIP: begin
            // swap as above, then step the digit down
            acc_nxt       = ram_nibble_in;
            ram_we_nxt    = 1'h1;
            ram_wdata_nxt = acc_r;
            ram_waddr_nxt = {page_r, file_r, digit_r};
            file_nxt      = file_xor;
            digit_nxt     = digit_dn;
            skip_next_nxt = (digit_dn == `NXRAE_DIGIT_WRAP_DN);
          end
          nxrae_pkg::NXRAE_RAM_SWAP_INC_SKIP: begin
            // swap as above, then step the digit up
            acc_nxt       = ram_nibble_in;
            ram_we_nxt    = 1'h1;
            ram_wdata_nxt = acc_r;
            ram_waddr_nxt = {page_r, file_r, digit_r};
            file_nxt      = file_xor;
            digit_nxt     = digit_up;
            skip_next_nxt = (digit_up == `NXRAE_DIGIT_WRAP_UP);
          end
          nxrae_pkg::NXRAE_RAM_STORE_ACC: begin
            // accumulator kept; ram nibble written and file takes file xor j
            ram_we_nxt    = 1'h1;
            ram_wdata_nxt = acc_r;
            ram_waddr_nxt = {page_r, file_r, digit_r};
            file_nxt      = file_xor;
          end
          default: begin
            // other instruction groups: nothing here
          end
        endcase
      end
    end
  end

  // register everything
  // reset loads constants only; every edge updates all state
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_r       <= `NXRAE_RST_NIB;
      second_r    <= `NXRAE_RST_NIB;
      wide_r      <= `NXRAE_RST_WIDE;
      digit_r     <= `NXRAE_RST_NIB;
      file_r      <= `NXRAE_RST_NIB;
      page_r      <= `NXRAE_RST_PAGE;
      table_ext_r <= `NXRAE_RST_TEXT;
      skip_next_r <= `NXRAE_RST_BIT;
      pair_run_r  <= `NXRAE_RST_BIT;
      ram_we_r    <= `NXRAE_RST_BIT;
      ram_wdata_r <= `NXRAE_RST_NIB;
      ram_waddr_r <= `NXRAE_RST_ADDR;
    end else begin
      acc_r       <= acc_nxt;
      second_r    <= second_nxt;
      wide_r      <= wide_nxt;
      digit_r     <= digit_nxt;
      file_r      <= file_nxt;
      page_r      <= page_nxt;
      table_ext_r <= table_ext_nxt;
      skip_next_r <= skip_next_nxt;
      pair_run_r  <= pair_run_nxt;
      ram_we_r    <= ram_we_nxt;
      ram_wdata_r <= ram_wdata_nxt;
      ram_waddr_r <= ram_waddr_nxt;
    end
  end

  // outputs straight from flip-flops
  // no logic between registers and ports, so nothing glitches outside
  assign acc_out       = acc_r;
  assign second_out    = second_r;
  assign wide_out      = wide_r;
  assign digit_out     = digit_r;
  assign file_out      = file_r;
  assign page_out      = page_r;
  assign table_ext_out = table_ext_r;
  assign skip_next_out = skip_next_r;
  assign ram_we_out    = ram_we_r;
  assign ram_wdata_out = ram_wdata_r;
  assign ram_waddr_out = ram_waddr_r;

endmodule

// ===== rtl/nxrae_pkg.sv
// types shared by the transfer execution block
package nxrae_pkg;

  // decoded instruction kinds, one-hot
  typedef enum logic [19:0] {
    NXRAE_NONE                  = 20'h00000,
    NXRAE_COPY_SECOND_TO_ACC    = 20'h00001,
    NXRAE_COPY_ACC_TO_SECOND    = 20'h00002,
    NXRAE_COPY_DIGIT_TO_ACC     = 20'h00004,
    NXRAE_COPY_ACC_TO_DIGIT     = 20'h00008,
    NXRAE_PACK_PAIR_TO_WIDE     = 20'h00010,
    NXRAE_UNPACK_WIDE_TO_PAIR   = 20'h00020,
    NXRAE_COPY_ACC_TO_TABLE_EXT = 20'h00040,
    NXRAE_COPY_TABLE_EXT_TO_ACC = 20'h00080,
    NXRAE_COPY_PAGE_TO_ACC      = 20'h00100,
    NXRAE_COPY_FILE_TO_ACC      = 20'h00200,
    NXRAE_COPY_STACKPTR_TO_ACC  = 20'h00400,
    NXRAE_LOAD_FILE_DIGIT_IMM   = 20'h00800,
    NXRAE_LOAD_PAGE_IMM         = 20'h01000,
    NXRAE_DIGIT_INCREMENT_SKIP  = 20'h02000,
    NXRAE_DIGIT_DECREMENT_SKIP  = 20'h04000,
    NXRAE_RAM_LOAD_ACC          = 20'h08000,
    NXRAE_RAM_SWAP_ACC          = 20'h10000,
    NXRAE_RAM_SWAP_DEC_SKIP     = 20'h20000,
    NXRAE_RAM_SWAP_INC_SKIP     = 20'h40000,
    NXRAE_RAM_STORE_ACC         = 20'h80000
  } nxrae_op_t;

endpackage

// ===== tb/nxrae_exec_monitor.sv
// port checker of the transfer execution block
`timescale 1ns/10ps
`include "nxrae_cfg.svh"
module nxrae_exec_monitor (
  input wire logic       clk_in,
  input wire logic       resetn_in,
  input wire logic       exec_in,
  input wire logic [9:0] instr_in,
  input wire logic       skip_in,
  input wire logic [3:0] ram_nibble_in,
  input wire logic [2:0] stack_pointer_in,
  input wire logic [3:0] acc_out,
  input wire logic [3:0] second_out,
  input wire logic [7:0] wide_out,
  input wire logic [3:0] digit_out,
  input wire logic [3:0] file_out,
  input wire logic [1:0] page_out,
  input wire logic [2:0] table_ext_out,
  input wire logic       skip_next_out,
  input wire logic       ram_we_out,
  input wire logic [3:0] ram_wdata_out,
  input wire logic [9:0] ram_waddr_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic       go;          // executed, not skipped
  logic       pair_r;      // last presented word was a pair load
  logic       pair_nxt;    // next value of pair_r
  logic       pair_ld;     // pair load presented
  logic [5:0] pfx;         // ram group prefix
  assign go  = exec_in && !skip_in;
  assign pfx = instr_in[9:4];
  assign pair_ld = exec_in && (instr_in[9:8] == `NXRAE_PAIR_PFX);
  // a run is broken only by another presented word
  always_comb begin
    pair_nxt = pair_r;
    if (exec_in) begin
      pair_nxt = pair_ld;
    end
  end
  // run tracker register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pair_r <= 1'h0;
    end else begin
      pair_r <= pair_nxt;
    end
  end
  // file register takes file xor j
  sequence s_file_xor;
    file_out == ($past(file_out) ^ $past(instr_in[3:0]));
  endsequence
  // old accumulator written at old pointer
  sequence s_old_acc;
    ram_we_out && ram_wdata_out == $past(acc_out)
      && ram_waddr_out == $past({page_out, file_out, digit_out});
  endsequence
  a_store_write: assert property (go && pfx == `NXRAE_PFX_RAM_STORE
    |=> s_old_acc ##0 s_file_xor) else $error("ram store wrong");
  a_swap_exchange: assert property (go && pfx == `NXRAE_PFX_RAM_SWAP
    |=> acc_out == $past(ram_nibble_in) ##0 s_old_acc ##0 s_file_xor) else $error("swap wrong");
  a_load_acc: assert property (go && pfx == `NXRAE_PFX_RAM_LOAD
    |=> acc_out == $past(ram_nibble_in) && !ram_we_out ##0 s_file_xor) else $error("load wrong");
  a_inc_skip: assert property (go && (instr_in == `NXRAE_OP_DIGIT_INC || pfx == 6'h2e)
    |=> digit_out == $past(digit_out) + 4'h1 && skip_next_out == (digit_out == 4'h0))
    else $error("increment skip wrong");
  a_dec_skip: assert property (go && (instr_in == `NXRAE_OP_DIGIT_DEC || pfx == 6'h2f)
    |=> digit_out == $past(digit_out) - 4'h1 && skip_next_out == (digit_out == 4'hf))
    else $error("decrement skip wrong");
  a_pair_load: assert property (pair_ld && !skip_in && !pair_r
    |=> {file_out, digit_out} == $past(instr_in[7:0])) else $error("pair load wrong");
  a_pair_run: assert property (pair_ld && pair_r
    |=> $stable(file_out) && $stable(digit_out)) else $error("pair run not skipped");
  a_skip_idle: assert property (exec_in && skip_in
    |=> $stable(acc_out) && $stable(file_out) && !ram_we_out && !skip_next_out)
    else $error("skipped word acted");
  a_text_acc: assert property (go && instr_in == `NXRAE_OP_TEXT_TO_ACC
    |=> acc_out == {1'h0, $past(table_ext_out)}) else $error("table ext copy wrong");
endmodule

bind nxrae_exec nxrae_exec_monitor mon (.clk_in(clk_in), .resetn_in(resetn_in),
  .exec_in(exec_in), .instr_in(instr_in), .skip_in(skip_in), .ram_nibble_in(ram_nibble_in),
  .stack_pointer_in(stack_pointer_in), .acc_out(acc_out), .second_out(second_out),
  .wide_out(wide_out), .digit_out(digit_out), .file_out(file_out), .page_out(page_out),
  .table_ext_out(table_ext_out), .skip_next_out(skip_next_out), .ram_we_out(ram_we_out),
  .ram_wdata_out(ram_wdata_out), .ram_waddr_out(ram_waddr_out));

// ===== tb/tb_top.sv
// self-checking bench of the transfer execution block
`timescale 1ns/10ps
`include "nxrae_cfg.svh"
module tb_top;
  logic       clk_in, resetn_in, exec_in, skip_in;   // control inputs
  logic [9:0] instr_in;                              // instruction word
  logic [3:0] ram_nibble_in;                         // ram read data
  logic [2:0] stack_pointer_in;                      // stack pointer
  logic [3:0] acc_out, second_out, digit_out, file_out, ram_wdata_out;
  logic [7:0] wide_out;
  logic [1:0] page_out;
  logic [2:0] table_ext_out;
  logic       skip_next_out, ram_we_out;
  logic [9:0] ram_waddr_out;
  int         errors, compares, cycles;              // tallies
  nxrae_exec uut (.clk_in(clk_in), .resetn_in(resetn_in), .exec_in(exec_in),
    .instr_in(instr_in), .skip_in(skip_in), .ram_nibble_in(ram_nibble_in),
    .stack_pointer_in(stack_pointer_in), .acc_out(acc_out), .second_out(second_out),
    .wide_out(wide_out), .digit_out(digit_out), .file_out(file_out), .page_out(page_out),
    .table_ext_out(table_ext_out), .skip_next_out(skip_next_out),
    .ram_we_out(ram_we_out), .ram_wdata_out(ram_wdata_out), .ram_waddr_out(ram_waddr_out));
  // 100 mhz clock
  initial begin
    clk_in = 1'h0;
    forever #5 clk_in = ~clk_in;
  end
  // hang guard
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      end_sim();
    end
  end
  // verdict and stop
  task end_sim();
    if (errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // value compare
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // present one word; returns just after it took effect
  task automatic run(input logic [9:0] op, input logic sk, input logic [3:0] nib);
    @(posedge clk_in);
    exec_in <= 1'h1;
    instr_in <= op;
    skip_in <= sk;
    ram_nibble_in <= nib;
    @(posedge clk_in);
    exec_in <= 1'h0;
    skip_in <= 1'h0;
    #1;
  endtask
  // outputs after reset
  task t_reset();
    chk(10'({acc_out, second_out}), 10'h000);
    chk(10'(table_ext_out), 10'h000);
    chk({page_out, file_out, digit_out}, 10'h000);
    chk({wide_out, skip_next_out, ram_we_out}, 10'h000);
    chk(10'(ram_wdata_out), 10'h000);
    chk(ram_waddr_out, 10'h000);
  endtask
  // register to register transfers
  task t_regs();
    run(10'h2c0, 1'h0, 4'h5);
    chk(10'(acc_out), 10'h005);
    chk(10'(ram_we_out), 10'h000);
    run(`NXRAE_OP_ACC_TO_SECOND, 1'h0, 4'h0);
    chk(10'({second_out, acc_out}), 10'h055);
    run(10'h2c0, 1'h0, 4'ha);
    run(`NXRAE_OP_SECOND_TO_ACC, 1'h0, 4'h0);
    chk(10'({second_out, acc_out}), 10'h055);
    run(10'h2c0, 1'h0, 4'ha);
    run(`NXRAE_OP_PAIR_TO_WIDE, 1'h0, 4'h0);
    chk(10'(wide_out), 10'h05a);
    run(10'h2c0, 1'h0, 4'h3);
    run(`NXRAE_OP_ACC_TO_SECOND, 1'h0, 4'h0);
    run(`NXRAE_OP_WIDE_TO_PAIR, 1'h0, 4'h0);
    chk(10'({second_out, acc_out}), 10'h05a);
    run(`NXRAE_OP_ACC_TO_DIGIT, 1'h0, 4'h0);
    chk(10'(digit_out), 10'h00a);
    run(10'h2c0, 1'h0, 4'he);
    run(`NXRAE_OP_DIGIT_TO_ACC, 1'h0, 4'h0);
    chk(10'(acc_out), 10'h00a);
    run(10'h2c0, 1'h0, 4'he);
    run(`NXRAE_OP_ACC_TO_TEXT, 1'h0, 4'h0);
    chk(10'(table_ext_out), 10'h006);
    run(`NXRAE_OP_TEXT_TO_ACC, 1'h0, 4'h0);
    chk(10'(acc_out), 10'h006);
    run(10'h04b, 1'h0, 4'h0);
    chk(10'(page_out), 10'h003);
    run(`NXRAE_OP_PAGE_TO_ACC, 1'h0, 4'h0);
    chk(10'(acc_out), 10'h003);
    @(posedge clk_in);
    stack_pointer_in <= 3'h7;
    run(`NXRAE_OP_SPTR_TO_ACC, 1'h0, 4'h0);
    chk(10'(acc_out), 10'h007);
    run(10'h2c9, 1'h0, 4'h0);
    run(`NXRAE_OP_FILE_TO_ACC, 1'h0, 4'h0);
    chk(10'(acc_out), 10'h009);
  endtask
  // pair load runs, skipped members included
  task t_pairs();
    run(10'h3ab, 1'h0, 4'h0);
    chk(10'({file_out, digit_out}), 10'h0ab);
    run(10'h312, 1'h0, 4'h0);
    chk(10'({file_out, digit_out}), 10'h0ab);
    run(`NXRAE_OP_DIGIT_INC, 1'h0, 4'h0);
    run(10'h345, 1'h1, 4'h0);
    chk(10'({file_out, digit_out}), 10'h0ac);
    run(10'h367, 1'h0, 4'h0);
    chk(10'({file_out, digit_out}), 10'h0ac);
    run(`NXRAE_OP_DIGIT_INC, 1'h0, 4'h0);
    run(10'h30f, 1'h0, 4'h0);
    chk(10'({file_out, digit_out}), 10'h00f);
  endtask
  // digit steps at both wrap points
  task t_digit();
    run(`NXRAE_OP_DIGIT_INC, 1'h0, 4'h0);
    chk(10'({skip_next_out, digit_out}), 10'h010);
    run(`NXRAE_OP_DIGIT_INC, 1'h0, 4'h0);
    chk(10'({skip_next_out, digit_out}), 10'h001);
    run(`NXRAE_OP_DIGIT_DEC, 1'h0, 4'h0);
    chk(10'({skip_next_out, digit_out}), 10'h000);
    run(`NXRAE_OP_DIGIT_DEC, 1'h0, 4'h0);
    chk(10'({skip_next_out, digit_out}), 10'h01f);
  endtask
  // ram swaps and stores with pointer {3,x,f}, except the decrement swap at {3,2,0}
  task t_ram();
    run(10'h2c1, 1'h0, 4'h5);
    run(10'h2d3, 1'h0, 4'h9);
    chk(10'({acc_out, file_out}), 10'h092);
    chk(10'({ram_we_out, ram_wdata_out}), 10'h015);
    chk(ram_waddr_out, 10'h31f);
    @(posedge clk_in);
    #1;
    chk(10'(ram_we_out), 10'h000);
    run(10'h2e0, 1'h0, 4'h4);
    chk(10'({skip_next_out, acc_out, digit_out}), 10'h140);
    chk(10'({ram_we_out, ram_wdata_out}), 10'h019);
    run(10'h2f1, 1'h0, 4'h7);
    chk(10'({skip_next_out, acc_out, digit_out}), 10'h17f);
    chk(10'(file_out), 10'h003);
    run(10'h2b5, 1'h0, 4'h0);
    chk(10'({ram_we_out, ram_wdata_out, file_out}), 10'h176);
    chk(ram_waddr_out, 10'h33f);
    run(10'h2b5, 1'h1, 4'h0);
    chk(10'({ram_we_out, ram_wdata_out, file_out}), 10'h076);
  endtask
  // main sequence
  initial begin
    errors = 0;
    compares = 0;
    cycles = 0;
    resetn_in = 1'h0;
    exec_in = 1'h0;
    skip_in = 1'h0;
    instr_in = 10'h000;
    ram_nibble_in = 4'h0;
    stack_pointer_in = 3'h2;
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'h1;
    #1;
    t_reset();
    t_regs();
    t_pairs();
    t_digit();
    t_ram();
    end_sim();
  end
endmodule
